//--- design/fcs_params.svh
// Constants for the flash command sequencer (host side).
// Assumes a parallel NOR flash with word/byte mode and banked address space.
// Behaviour
// - One write of F0 to any address returns a bank to read mode.
// - Autoselect entry: AA to 555, 55 to 2AA, 90 to bank 555; then reads.
// - Maker code is read at bank offset X00, low data byte.
// - Device identifier needs three reads at X01, X0E and X0F.
// - Host keeps the same bank address through autoselect reads until reset.
// - Program: AA 555, 55 2AA, A0 555, then data to target.
// - Bypass entry AA/55/20; bypass program is A0 anywhere then data to target.
// - Bypass exit is 90 then 00 to any address.
// - Sector erase: AA,55,80,AA,55 then 30 to sector; A20-A12 select sector.
// - During erase time-out each extra sector is one write of 30.
// - Query is one write of 98 to 55 (word) or AA (byte).
// - All command cycles are writes except array reads and autoselect reads.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_AW 21
`define FCS_DW 16
// Unlock and query addresses, word and byte
`define FCS_U1_W 21'h000555
`define FCS_U2_W 21'h0002aa
`define FCS_U1_B 21'h000aaa
`define FCS_U2_B 21'h000555
`define FCS_QRY_W 21'h000055
`define FCS_QRY_B 21'h0000aa
// Command data
`define FCS_D_AA 16'h00aa
`define FCS_D_55 16'h0055
`define FCS_D_90 16'h0090
`define FCS_D_A0 16'h00a0
`define FCS_D_20 16'h0020
`define FCS_D_00 16'h0000
`define FCS_D_80 16'h0080
`define FCS_D_10 16'h0010
`define FCS_D_30 16'h0030
`define FCS_D_B0 16'h00b0
`define FCS_D_F0 16'h00f0
`define FCS_D_98 16'h0098
// Bank field and low-address field
`define FCS_BANK_MASK 21'h1c0000
`define FCS_LOW_MASK 21'h0007ff
// Time-out window and bus strobe timing
`define FCS_CLK_MHZ 25
`define FCS_ERASE_WIN_US 50
`define FCS_ERASE_WIN_CYC (`FCS_ERASE_WIN_US * `FCS_CLK_MHZ)
`define FCS_PH_CYC 4'h3
`endif

//--- design/fcs_pkg.sv
// Types for the flash command sequencer.
// Assumes fcs_params.svh is compiled alongside.
package fcs_pkg;
  // Host operation codes
  typedef enum logic [3:0] {
    FCS_OP_RESET = 4'h0,
    FCS_OP_READ = 4'h1,
    FCS_OP_ASEL = 4'h2,
    FCS_OP_PROG = 4'h3,
    FCS_OP_BYP_ENTER = 4'h4,
    FCS_OP_BYP_PROG = 4'h5,
    FCS_OP_BYP_EXIT = 4'h6,
    FCS_OP_CHIP_ERASE = 4'h7,
    FCS_OP_SECT_ERASE = 4'h8,
    FCS_OP_SECT_ADD = 4'h9,
    FCS_OP_SUSPEND = 4'ha,
    FCS_OP_RESUME = 4'hb,
    FCS_OP_QUERY = 4'hc
  } fcs_op_t;
  // Cycle kind handed to the bus engine
  typedef enum logic [1:0] {
    FCS_CY_WR = 2'h0,
    FCS_CY_RD = 2'h1
  } fcs_cy_t;
endpackage : fcs_pkg

//--- design/fcs_bus_if.sv
// Link between sequencer and bus-cycle engine.
// Assumes one clock for both ends.
`timescale 1ns/1ps
interface fcs_bus_if;
  logic req;
  logic done;
  fcs_pkg::fcs_cy_t kind;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport seq(output req, output kind, output addr, output wdata, input done, input rdata);
  modport eng(input req, input kind, input addr, input wdata, output done, output rdata);
endinterface : fcs_bus_if

//--- design/fcs_bus_cycle.sv
// One flash bus cycle: write or read with enable strobes.
// Assumes flash pins; data input resynchronised here.
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_bus_cycle (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Sequencer side
  fcs_bus_if.eng bus,
  // Flash pins
  output logic [20:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  typedef enum logic [1:0] {
    FCS_BC_IDLE = 2'h0,
    FCS_BC_SETUP = 2'h1,
    FCS_BC_ACT = 2'h2,
    FCS_BC_HOLD = 2'h3
  } fcs_bc_t;
  fcs_bc_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic [20:0] addr_r, addr_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic [15:0] sync1_r, sync2_r;
  logic done_r, done_nxt;
  // ----------------------------------------------------------------
  // Next-state for one strobe
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    rdat_nxt = rdat_r;
    done_nxt = 1'b0;
    case (st_r)
      FCS_BC_IDLE: begin
        if (bus.req) begin
          addr_nxt = bus.addr;
          dout_nxt = bus.wdata;
          rd_nxt = (bus.kind == fcs_pkg::FCS_CY_RD);
          cnt_nxt = 4'h0;
          st_nxt = FCS_BC_SETUP;
        end
      end
      FCS_BC_SETUP: begin
        st_nxt = FCS_BC_ACT;
        cnt_nxt = 4'h0;
      end
      FCS_BC_ACT: begin
        cnt_nxt = cnt_r + 4'h1;
        // Read data sampled after two-stage sync settles
        if (cnt_r == `FCS_PH_CYC) begin
          rdat_nxt = sync2_r;
          st_nxt = FCS_BC_HOLD;
          cnt_nxt = 4'h0;
        end
      end
      default: begin
        done_nxt = 1'b1;
        st_nxt = FCS_BC_IDLE;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= FCS_BC_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      addr_r <= 21'h000000;
      dout_r <= 16'h0000;
      rdat_r <= 16'h0000;
      done_r <= 1'b0;
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      rdat_r <= rdat_nxt;
      done_r <= done_nxt;
      sync1_r <= i_dq_in;
      sync2_r <= sync1_r;
    end
  end
  // Pin drive: chip enable spans setup..hold, strobe only in ACT
  assign o_addr = addr_r;
  assign o_dq_out = dout_r;
  assign o_dq_oe = (st_r != FCS_BC_IDLE) && !rd_r;
  assign o_ce_n = (st_r == FCS_BC_IDLE);
  assign o_we_n = !((st_r == FCS_BC_ACT) && !rd_r);
  assign o_oe_n = !((st_r == FCS_BC_ACT) && rd_r);
  assign bus.done = done_r;
  assign bus.rdata = rdat_r;
endmodule : fcs_bus_cycle

//--- design/fcs_seq.sv
// Host-side command sequencer for a banked parallel NOR flash.
// Assumes a single 25 MHz clock; user issues one operation at a time.
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_seq (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // User request
  input wire logic i_req,
  input wire logic [3:0] i_op,
  input wire logic i_byte_mode,
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_data,
  output logic o_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_erase_window,
  // Flash pins
  output logic [20:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  typedef enum logic [1:0] {
    FCS_S_IDLE = 2'h0,
    FCS_S_ISSUE = 2'h1,
    FCS_S_WAIT = 2'h2,
    FCS_S_FIN = 2'h3
  } fcs_st_t;
  fcs_bus_if bus();
  fcs_st_t st_r, st_nxt;
  fcs_pkg::fcs_op_t op_r, op_nxt;
  logic byte_r, byte_nxt;
  logic [20:0] uaddr_r, uaddr_nxt;
  logic [15:0] udata_r, udata_nxt;
  logic [2:0] step_r, step_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [10:0] win_r, win_nxt;
  logic done_r, done_nxt;
  logic [2:0] nsteps;
  fcs_pkg::fcs_cy_t cy_kind;
  logic [20:0] cy_addr;
  logic [15:0] cy_data;

  // ----------------------------------------------------------------
  // Bank part of an address, low bits cleared
  // ----------------------------------------------------------------
  function automatic logic [20:0] bank_of(input logic [20:0] a);
    bank_of = a & `FCS_BANK_MASK;
  endfunction : bank_of

  // Unlock address pick by mode: first or second unlock
  function automatic logic [20:0] unl(input logic second, input logic bm);
    if (second) unl = bm ? `FCS_U2_B : `FCS_U2_W;
    else unl = bm ? `FCS_U1_B : `FCS_U1_W;
  endfunction : unl

  // ----------------------------------------------------------------
  // Cycle count per operation
  // ----------------------------------------------------------------
  always_comb begin
    case (op_r)
      fcs_pkg::FCS_OP_RESET, fcs_pkg::FCS_OP_READ, fcs_pkg::FCS_OP_SECT_ADD,
      fcs_pkg::FCS_OP_SUSPEND, fcs_pkg::FCS_OP_RESUME,
      fcs_pkg::FCS_OP_QUERY: nsteps = 3'h1;
      fcs_pkg::FCS_OP_BYP_PROG, fcs_pkg::FCS_OP_BYP_EXIT: nsteps = 3'h2;
      fcs_pkg::FCS_OP_BYP_ENTER: nsteps = 3'h3;
      fcs_pkg::FCS_OP_PROG, fcs_pkg::FCS_OP_ASEL: nsteps = 3'h4;
      default: nsteps = 3'h6;
    endcase
  end

  // ----------------------------------------------------------------
  // Address and data of the current bus cycle
  // ----------------------------------------------------------------
  always_comb begin
    cy_kind = fcs_pkg::FCS_CY_WR;
    cy_addr = unl(1'b0, byte_r);
    cy_data = `FCS_D_AA;
    case (op_r)
      fcs_pkg::FCS_OP_RESET: begin
        cy_data = `FCS_D_F0;
      end
      fcs_pkg::FCS_OP_READ: begin
        cy_kind = fcs_pkg::FCS_CY_RD;
        cy_addr = uaddr_r;
      end
      fcs_pkg::FCS_OP_QUERY: begin
        cy_addr = byte_r ? `FCS_QRY_B : `FCS_QRY_W;
        cy_data = `FCS_D_98;
      end
      fcs_pkg::FCS_OP_SUSPEND: begin
        cy_addr = bank_of(uaddr_r);
        cy_data = `FCS_D_B0;
      end
      fcs_pkg::FCS_OP_RESUME: begin
        cy_addr = bank_of(uaddr_r);
        cy_data = `FCS_D_30;
      end
      fcs_pkg::FCS_OP_SECT_ADD: begin
        cy_addr = uaddr_r;
        cy_data = `FCS_D_30;
      end
      fcs_pkg::FCS_OP_BYP_PROG: begin
        cy_addr = (step_r == 3'h0) ? 21'h000000 : uaddr_r;
        cy_data = (step_r == 3'h0) ? `FCS_D_A0 : udata_r;
      end
      fcs_pkg::FCS_OP_BYP_EXIT: begin
        cy_addr = 21'h000000;
        cy_data = (step_r == 3'h0) ? `FCS_D_90 : `FCS_D_00;
      end
      default: begin
        // Unlock pair, command, optionally a second unlock pair
        if (step_r == 3'h1 || step_r == 3'h4) begin
          cy_addr = unl(1'b1, byte_r);
          cy_data = `FCS_D_55;
        end else if (step_r == 3'h3) begin
          cy_data = `FCS_D_AA;
          cy_addr = unl(1'b0, byte_r);
          if (op_r == fcs_pkg::FCS_OP_PROG) begin
            cy_addr = uaddr_r;
            cy_data = udata_r;
          end else if (op_r == fcs_pkg::FCS_OP_ASEL) begin
            cy_kind = fcs_pkg::FCS_CY_RD;
            cy_addr = bank_of(uaddr_r) | (uaddr_r & `FCS_LOW_MASK);
          end
        end else if (step_r == 3'h2) begin
          if (op_r == fcs_pkg::FCS_OP_ASEL) begin
            cy_addr = bank_of(uaddr_r) | unl(1'b0, byte_r);
            cy_data = `FCS_D_90;
          end else if (op_r == fcs_pkg::FCS_OP_PROG) begin
            cy_data = `FCS_D_A0;
          end else if (op_r == fcs_pkg::FCS_OP_BYP_ENTER) begin
            cy_data = `FCS_D_20;
          end else begin
            cy_data = `FCS_D_80;
          end
        end else if (step_r == 3'h5) begin
          if (op_r == fcs_pkg::FCS_OP_SECT_ERASE) begin
            cy_addr = uaddr_r;
            cy_data = `FCS_D_30;
          end else begin
            cy_data = `FCS_D_10;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    byte_nxt = byte_r;
    uaddr_nxt = uaddr_r;
    udata_nxt = udata_r;
    step_nxt = step_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    win_nxt = (win_r != 11'h000) ? win_r - 11'h001 : win_r;
    case (st_r)
      FCS_S_IDLE: begin
        if (i_req) begin
          op_nxt = fcs_pkg::fcs_op_t'(i_op);
          byte_nxt = i_byte_mode;
          uaddr_nxt = i_addr;
          udata_nxt = {8'h00, i_data[7:0]};
          if (i_op == fcs_pkg::FCS_OP_PROG || i_op == fcs_pkg::FCS_OP_BYP_PROG) begin
            udata_nxt = i_data;
          end
          step_nxt = 3'h0;
          st_nxt = FCS_S_ISSUE;
        end
      end
      FCS_S_ISSUE: begin
        st_nxt = FCS_S_WAIT;
      end
      FCS_S_WAIT: begin
        if (bus.done) begin
          if (step_r == nsteps - 3'h1) begin
            rdata_nxt = bus.rdata;
            st_nxt = FCS_S_FIN;
          end else begin
            step_nxt = step_r + 3'h1;
            st_nxt = FCS_S_ISSUE;
          end
        end
      end
      default: begin
        done_nxt = 1'b1;
        st_nxt = FCS_S_IDLE;
        // Erase window restarts on every sector write
        if (op_r == fcs_pkg::FCS_OP_SECT_ERASE || op_r == fcs_pkg::FCS_OP_SECT_ADD) begin
          win_nxt = 11'(`FCS_ERASE_WIN_CYC);
        end else if (op_r == fcs_pkg::FCS_OP_SUSPEND) begin
          win_nxt = 11'h000;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= FCS_S_IDLE;
      op_r <= fcs_pkg::FCS_OP_RESET;
      byte_r <= 1'b0;
      uaddr_r <= 21'h000000;
      udata_r <= 16'h0000;
      step_r <= 3'h0;
      rdata_r <= 16'h0000;
      win_r <= 11'h000;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      byte_r <= byte_nxt;
      uaddr_r <= uaddr_nxt;
      udata_r <= udata_nxt;
      step_r <= step_nxt;
      rdata_r <= rdata_nxt;
      win_r <= win_nxt;
      done_r <= done_nxt;
    end
  end

  // Bus request for the current step
  assign bus.req = (st_r == FCS_S_ISSUE);
  assign bus.kind = cy_kind;
  assign bus.addr = cy_addr;
  assign bus.wdata = cy_data;

  // Cycle engine
  fcs_bus_cycle u_cyc (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .bus(bus),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe),
    .i_dq_in(i_dq_in),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n)
  );

  assign o_ready = (st_r == FCS_S_IDLE);
  assign o_done = done_r;
  assign o_rdata = rdata_r;
  assign o_erase_window = (win_r != 11'h000);
endmodule : fcs_seq

//--- tb/fcs_seq_checker.sv
// Assertions on the sequencer strobes, pins and user handshake.
// Assumes a bind onto fcs_seq; one clock, synchronous reset.
`timescale 1ns/1ps
module fcs_seq_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // User side
  input wire logic i_req,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_erase_window,
  // Flash pins
  input wire logic [20:0] o_addr,
  input wire logic [15:0] o_dq_out,
  input wire logic o_dq_oe,
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_oe_n
);
  logic [11:0] gap_r;
  logic [11:0] gap_nxt;
  default clocking dflt_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // ----
  // Cycles since the last write strobe
  // ----
  always_comb begin
    gap_nxt = gap_r;
    if (!o_we_n) begin
      gap_nxt = 12'h000;
    end else if (gap_r != 12'hfff) begin
      gap_nxt = gap_r + 12'h001;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gap_r <= 12'h000;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  // ----
  // Properties
  // ----
  a_strobe_excl: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and read strobes low together");
  a_write_drive: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
    else $error("write strobe without select or data drive");
  a_read_float: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe)
    else $error("read strobe without select or with data drive");
  a_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(o_oe_n) |-> !o_oe_n [*4] ##1 o_oe_n)
    else $error("read strobe width wrong");
  a_addr_hold: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_addr) && $stable(o_dq_out))
    else $error("address or data moved during write strobe");
  a_done_idle: assert property (o_done |-> o_ce_n && o_we_n && o_oe_n ##1 !o_done)
    else $error("done while strobes active or longer than one cycle");
  a_take_busy: assert property (i_req && o_ready |=> !o_ready)
    else $error("request taken but still ready");
  a_win_bound: assert property (o_erase_window |-> gap_r < 12'h4f6)
    else $error("erase window open too long after last write");
endmodule : fcs_seq_checker
bind fcs_seq fcs_seq_checker chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req),
  .o_ready(o_ready), .o_done(o_done), .o_erase_window(o_erase_window), .o_addr(o_addr),
  .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));

//--- tb/fcs_flash_model.sv
// Flash model: logs write cycles, answers array and identification reads.
// Assumes strobes from the sequencer; no clock of its own.
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [7:0] MAKER = 8'hc3, // Arbitrary maker code
  parameter logic [7:0] LOCK = 8'h82
) (
  // Host pins
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  // Data back to host
  output logic [15:0] o_dq
);
  logic [20:0] lat_a;
  logic [20:0] rd_a;
  logic [15:0] rd_v;
  logic [20:0] log_a [16];
  logic [15:0] log_d [16];
  logic [7:0] prev_d = 8'h00;
  logic asel = 1'b0;
  int n_wr = 0;
  // Address on falling strobe, data on rising strobe
  always @(negedge i_we_n) if (!i_ce_n) lat_a = i_addr;
  always @(posedge i_we_n) begin
    if (!i_ce_n && n_wr < 16) begin
      log_a[n_wr] = lat_a;
      log_d[n_wr] = i_dq;
      n_wr++;
      if (i_dq[7:0] == 8'hf0) asel = 1'b0;
      if (i_dq[7:0] == 8'h90 && prev_d == 8'h55) asel = 1'b1;
      prev_d = i_dq[7:0];
    end
  end
  // Read address capture
  always @(negedge i_oe_n) if (!i_ce_n) rd_a = i_addr;
  // Identification codes by low offset in autoselect (dead elsewhere), else array pattern
  always_comb begin
    case (i_addr[7:0])
      8'h00: rd_v = {8'h5c, MAKER};
      8'h01, 8'h0e, 8'h0f: rd_v = {8'h5c, 4'h7, i_addr[3:0]};
      8'h02: rd_v = {8'h5c, 7'h00, i_addr[18]};
      8'h03: rd_v = {8'h5c, LOCK};
      default: rd_v = 16'hdead;
    endcase
    if (!asel) rd_v = i_addr[15:0] ^ 16'h5a5a;
  end
  // Released bus shows the inverse
  assign o_dq = (!i_ce_n && !i_oe_n) ? rd_v : ~rd_v;
endmodule : fcs_flash_model

//--- tb/flash_command_sequence_decoder_tb.sv
// Self-checking bench for the flash command sequencer.
// Assumes fcs_seq, the flash model and the checker bind are compiled.
`timescale 1ns/1ps
`include "fcs_params.svh"
module flash_command_sequence_decoder_tb;
  typedef logic [20:0] fcs_av_t [6];
  typedef logic [15:0] fcs_dv_t [6];
  localparam logic [20:0] U1 = `FCS_U1_W;
  localparam logic [20:0] U2 = `FCS_U2_W;
  localparam logic [20:0] B1 = `FCS_U1_B;
  localparam logic [20:0] B2 = `FCS_U2_B;
  localparam logic [7:0] MAKER = 8'hc3; // Arbitrary maker code
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic [3:0] i_op = 4'h0;
  logic i_byte_mode = 1'b0;
  logic [20:0] i_addr = 21'h000000;
  logic [15:0] i_data = 16'h0000;
  logic o_ready, o_done, o_erase_window, o_dq_oe, o_ce_n, o_we_n, o_oe_n;
  logic [15:0] o_rdata, o_dq_out, i_dq_in;
  logic [20:0] o_addr;
  int errors = 0;
  int total_checks = 0;
  // ----
  // Design and flash model
  // ----
  fcs_seq dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req), .i_op(i_op),
    .i_byte_mode(i_byte_mode), .i_addr(i_addr), .i_data(i_data), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_erase_window(o_erase_window), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  fcs_flash_model #(.MAKER(MAKER), .LOCK(8'h82)) flash_u (.i_addr(o_addr), .i_dq(o_dq_out),
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .o_dq(i_dq_in));
  // Clock
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // One operation: request for one edge, bounded wait for done
  task automatic do_op(input fcs_pkg::fcs_op_t op, input logic bm, input logic [20:0] a,
    input logic [15:0] d);
    int k;
    @(negedge i_clk_sys);
    flash_u.n_wr = 0;
    i_req = 1'b1;
    i_op = op;
    i_byte_mode = bm;
    i_addr = a;
    i_data = d;
    @(negedge i_clk_sys);
    i_req = 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 300) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (k == 300) begin
      check("op done", 21'h1, 21'h0);
      complete_run();
    end
  endtask : do_op
  // Compare logged writes with the expected list
  task automatic chk_wr(input int n, input fcs_av_t a, input fcs_dv_t d);
    check("write count", 21'(n), 21'(flash_u.n_wr));
    for (int i = 0; i < n; i++) begin
      check("write addr", a[i], flash_u.log_a[i]);
      check("write data", {5'h00, d[i]}, {5'h00, flash_u.log_d[i]});
    end
  endtask : chk_wr
  // ----
  // Scenarios
  // ----
  task automatic s_prog();
    logic [20:0] a1;
    logic [20:0] a2;
    for (int b = 0; b < 2; b++) begin
      a1 = b ? B1 : U1;
      a2 = b ? B2 : U2;
      do_op(fcs_pkg::FCS_OP_PROG, b[0], 21'h0d1234, 16'hbe5a);
      chk_wr(4, '{a1, a2, a1, 21'h0d1234, 0, 0}, '{16'haa, 16'h55, 16'ha0, 16'hbe5a, 0, 0});
    end
  endtask : s_prog
  task automatic s_asel();
    logic [7:0] off [6] = '{8'h00, 8'h01, 8'h0e, 8'h0f, 8'h02, 8'h03};
    logic [7:0] exp [6] = '{MAKER, 8'h71, 8'h7e, 8'h7f, 8'h01, 8'h82};
    for (int i = 0; i < 6; i++) begin
      do_op(fcs_pkg::FCS_OP_ASEL, 1'b0, 21'h0c0000 | 21'(off[i]), 16'h0000);
      chk_wr(3, '{U1, U2, 21'h0c0555, 0, 0, 0}, '{16'haa, 16'h55, 16'h90, 0, 0, 0});
      check("id addr", 21'h0c0000 | 21'(off[i]), flash_u.rd_a);
      check("id byte", 21'(exp[i]), 21'(o_rdata[7:0]));
    end
    do_op(fcs_pkg::FCS_OP_RESET, 1'b0, 21'h1abcde, 16'hff12);
    check("reset data", 21'h0000f0, 21'(flash_u.log_d[0]));
    do_op(fcs_pkg::FCS_OP_READ, 1'b0, 21'h012345, 16'h0000);
    check("read writes", 21'h0, 21'(flash_u.n_wr));
    check("read data", 21'(16'h2345 ^ 16'h5a5a), 21'(o_rdata));
  endtask : s_asel
  task automatic s_bypass();
    do_op(fcs_pkg::FCS_OP_BYP_ENTER, 1'b0, 21'h0, 16'h0000);
    chk_wr(3, '{U1, U2, U1, 0, 0, 0}, '{16'haa, 16'h55, 16'h20, 0, 0, 0});
    do_op(fcs_pkg::FCS_OP_BYP_PROG, 1'b0, 21'h054321, 16'h1357);
    chk_wr(2, '{0, 21'h054321, 0, 0, 0, 0}, '{16'ha0, 16'h1357, 0, 0, 0, 0});
    do_op(fcs_pkg::FCS_OP_BYP_EXIT, 1'b0, 21'h0, 16'h0000);
    chk_wr(2, '{0, 0, 0, 0, 0, 0}, '{16'h90, 16'h00, 0, 0, 0, 0});
  endtask : s_bypass
  task automatic s_erase();
    int k;
    do_op(fcs_pkg::FCS_OP_CHIP_ERASE, 1'b1, 21'h0, 16'h0000);
    chk_wr(6, '{B1, B2, B1, B1, B2, B1}, '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55, 16'h10});
    do_op(fcs_pkg::FCS_OP_SECT_ERASE, 1'b0, 21'h0a3000, 16'h0000);
    chk_wr(6, '{U1, U2, U1, U1, U2, 21'h0a3000}, '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55, 16'h30});
    check("window open", 21'h1, 21'(o_erase_window));
    repeat (600) @(negedge i_clk_sys);
    do_op(fcs_pkg::FCS_OP_SECT_ADD, 1'b0, 21'h0a5000, 16'h0000);
    chk_wr(1, '{21'h0a5000, 0, 0, 0, 0, 0}, '{16'h30, 0, 0, 0, 0, 0});
    repeat (1000) @(negedge i_clk_sys);
    k = 0;
    while (o_erase_window === 1'b1 && k < 400) begin
      @(negedge i_clk_sys);
      k++;
    end
    check("window length", 21'h1, 21'(k >= 236 && k <= 252));
    do_op(fcs_pkg::FCS_OP_SUSPEND, 1'b0, 21'h0a5000, 16'h0000);
    chk_wr(1, '{21'h080000, 0, 0, 0, 0, 0}, '{16'hb0, 0, 0, 0, 0, 0});
    do_op(fcs_pkg::FCS_OP_RESUME, 1'b0, 21'h0a5000, 16'h0000);
    chk_wr(1, '{21'h080000, 0, 0, 0, 0, 0}, '{16'h30, 0, 0, 0, 0, 0});
  endtask : s_erase
  task automatic s_query();
    for (int b = 0; b < 2; b++) begin
      do_op(fcs_pkg::FCS_OP_QUERY, b[0], 21'h0, 16'h0000);
      chk_wr(1, '{b ? `FCS_QRY_B : `FCS_QRY_W, 0, 0, 0, 0, 0}, '{16'h98, 0, 0, 0, 0, 0});
    end
  endtask : s_query
  // Reset in mid-operation: outputs back to idle values, then a clean read
  task automatic s_reset();
    do_op(fcs_pkg::FCS_OP_SECT_ADD, 1'b0, 21'h0a5000, 16'h0000);
    check("add window", 21'h1, 21'(o_erase_window));
    @(negedge i_clk_sys);
    i_req = 1'b1;
    i_op = fcs_pkg::FCS_OP_PROG;
    i_byte_mode = 1'b0;
    i_addr = 21'h0d1234;
    @(negedge i_clk_sys);
    i_req = 1'b0;
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("reset ready", 21'h1, 21'(o_ready));
    check("reset strobes", 21'h7, 21'({o_ce_n, o_we_n, o_oe_n}));
    check("reset drive", 21'h0, 21'({o_done, o_dq_oe, o_erase_window}));
    check("reset rdata", 21'h0, 21'(o_rdata));
    do_op(fcs_pkg::FCS_OP_READ, 1'b0, 21'h012345, 16'h0000);
    check("read after reset", 21'(16'h2345 ^ 16'h5a5a), 21'(o_rdata));
  endtask : s_reset
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    s_prog();
    s_asel();
    s_bypass();
    s_erase();
    s_query();
    s_reset();
    complete_run();
  end
endmodule : flash_command_sequence_decoder_tb
